// ---- rtl/lcgis_top.sv ----
// Gate input select stage of a configurable logic cell, with an APB slave.
// Assumes a synchronous source bus and an APB master on the same clock.
//
// How it works
// R1 - Five-bit field bits 4..0 selects the fourth data input's source.
// R2 - Fourth selector bits 7..5 read zero and ignore writes.
// R3 - Gate one enables: odd bit true, even bit inverted, inputs four down to one.
// R4 - Gate two enable register uses the gate one layout.
// R5 - Gate three enable register uses the same layout; bit 0 is inverted input one.
// R6 - A cleared enable bit excludes that version; every bit acts independently.
// R7 - Selectors and enables are read/write and survive non-power resets.
// R8 - Data inputs one to three have their own five-bit selectors.
// R9 - Each gate output has its own polarity bit; set inverts it.
// R10 - A gate ORs its enabled versions, zero if none; inverted is the complement.
`timescale 1ns/1ps
`default_nettype none

module lcgis_top
    import lcgis_pkg::*;
#(
    parameter int NUM_SOURCES = 32
) (
    // Clock and reset.
    input  wire logic                       clk,
    input  wire logic                       rst,
    // APB slave.
    input  wire lcgis_apb_req_t             apbReq,
    output lcgis_apb_rsp_t                  apbRsp,
    // Source signals that the selectors choose from.
    input  wire logic [NUM_SOURCES-1:0]     sourceBus,
    // Gate outputs after polarity, toward the cell logic.
    output logic [`LCGIS_NUM_GATES-1:0]     gateOut
);

    lcgis_state_t state_reg;
    lcgis_state_t state_next;

    logic [`LCGIS_NUM_DATA-1:0]  dataTrue;
    logic [`LCGIS_NUM_GATES-1:0] gateComb;
    logic                        setupPhase;
    logic                        writeTaken;
    logic                        addrHit;
    logic [`LCGIS_DATA_W-1:0]    readWord;
    logic [`LCGIS_SEL_W-1:0]     writeSel;

    // Each data input takes the source that its selector names; a selector
    // value beyond the source count yields logic zero.
    always_comb
    begin
        for (int d = 0; d < `LCGIS_NUM_DATA; d++)
        begin
            if (int'(state_reg.srcSel[d]) < NUM_SOURCES)
            begin
                dataTrue[d] = sourceBus[state_reg.srcSel[d]];    // R1 R8
            end
            else
            begin
                dataTrue[d] = 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LCGIS_NUM_GATES; g++)
        begin : gGate
            lcgis_gate #(
                .NUM_INPUTS (`LCGIS_NUM_DATA)
            ) uGate (
                .dataTrue (dataTrue),
                .enable   (state_reg.gateEnable[g]),   // R3 R4 R5
                .invert   (state_reg.gateInvert[g]),   // R9
                .gateOut  (gateComb[g])
            );
        end
    endgenerate

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    // The slave answers in the first access cycle, so a write lands there.
    assign writeTaken = apbReq.psel & apbReq.penable & state_reg.rsp.pready & apbReq.pwrite;
    assign writeSel   = apbReq.pwdata[`LCGIS_SEL_MSB:`LCGIS_SEL_LSB];

    // Read mux, evaluated in the setup cycle and registered for the access.
    always_comb
    begin
        readWord = `LCGIS_RST_WORD;
        addrHit  = 1'b1;
        case (apbReq.paddr)
            `LCGIS_OFF_SEL1:   readWord[`LCGIS_SEL_MSB:`LCGIS_SEL_LSB] = state_reg.srcSel[0];
            `LCGIS_OFF_SEL2:   readWord[`LCGIS_SEL_MSB:`LCGIS_SEL_LSB] = state_reg.srcSel[1];
            `LCGIS_OFF_SEL3:   readWord[`LCGIS_SEL_MSB:`LCGIS_SEL_LSB] = state_reg.srcSel[2];
            `LCGIS_OFF_SEL4:   readWord[`LCGIS_SEL_MSB:`LCGIS_SEL_LSB] = state_reg.srcSel[3]; // R2
            `LCGIS_OFF_GATE1:  readWord[`LCGIS_GLS_W-1:0] = state_reg.gateEnable[0];  // R7
            `LCGIS_OFF_GATE2:  readWord[`LCGIS_GLS_W-1:0] = state_reg.gateEnable[1];  // R7
            `LCGIS_OFF_GATE3:  readWord[`LCGIS_GLS_W-1:0] = state_reg.gateEnable[2];  // R7
            `LCGIS_OFF_POL:    readWord[`LCGIS_NUM_GATES-1:0] = state_reg.gateInvert;
            `LCGIS_OFF_STATUS: readWord[`LCGIS_NUM_GATES-1:0] = state_reg.gateOut;
            default:           addrHit = 1'b0;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;

        // Zero-wait APB: ready and data rise for the access cycle only.
        state_next.rsp.pready  = setupPhase;
        state_next.rsp.pslverr = setupPhase & ~addrHit;
        state_next.rsp.prdata  = (setupPhase & ~apbReq.pwrite & addrHit)
                                 ? readWord : `LCGIS_RST_WORD;

        if (writeTaken)
        begin
            case (apbReq.paddr)
                `LCGIS_OFF_SEL1:  state_next.srcSel[0] = writeSel;           // R8
                `LCGIS_OFF_SEL2:  state_next.srcSel[1] = writeSel;           // R8
                `LCGIS_OFF_SEL3:  state_next.srcSel[2] = writeSel;           // R8
                `LCGIS_OFF_SEL4:  state_next.srcSel[3] = writeSel;           // R1 R2
                `LCGIS_OFF_GATE1:
                    state_next.gateEnable[0] = apbReq.pwdata[`LCGIS_GLS_W-1:0];  // R3 R6
                `LCGIS_OFF_GATE2:
                    state_next.gateEnable[1] = apbReq.pwdata[`LCGIS_GLS_W-1:0];  // R4 R6
                `LCGIS_OFF_GATE3:
                    state_next.gateEnable[2] = apbReq.pwdata[`LCGIS_GLS_W-1:0];  // R5 R6
                `LCGIS_OFF_POL:
                    state_next.gateInvert = apbReq.pwdata[`LCGIS_NUM_GATES-1:0]; // R9
                default:
                begin
                end
            endcase
        end

        // Gate outputs are sampled every cycle so the pins come from flops;
        // this costs one clock of latency against the asynchronous original.
        state_next.gateOut = gateComb;                                      // R10
    end

    // The only reset here stands for power-on, which leaves the selection in a
    // known zero state; there is no other reset that could disturb it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int d = 0; d < `LCGIS_NUM_DATA; d++)
            begin
                state_reg.srcSel[d] <= `LCGIS_RST_SEL;                      // R7
            end
            for (int k = 0; k < `LCGIS_NUM_GATES; k++)
            begin
                state_reg.gateEnable[k] <= `LCGIS_RST_GLS;                  // R7
            end
            state_reg.gateInvert  <= `LCGIS_RST_POL;
            state_reg.gateOut     <= `LCGIS_RST_GATE;
            state_reg.rsp.prdata  <= `LCGIS_RST_WORD;
            state_reg.rsp.pready  <= 1'b0;
            state_reg.rsp.pslverr <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign apbRsp  = state_reg.rsp;
    assign gateOut = state_reg.gateOut;

endmodule // lcgis_top

`default_nettype wire

// ---- common/lcgis_defs.svh ----
// Constants of the logic cell gate input select stage: register byte offsets,
// field positions, reset values and bus widths.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef LCGIS_DEFS_SVH
`define LCGIS_DEFS_SVH

`define LCGIS_ADDR_W        8
`define LCGIS_DATA_W        32

`define LCGIS_OFF_SEL1      8'h00
`define LCGIS_OFF_SEL2      8'h04
`define LCGIS_OFF_SEL3      8'h08
`define LCGIS_OFF_SEL4      8'h0C
`define LCGIS_OFF_GATE1     8'h10
`define LCGIS_OFF_GATE2     8'h14
`define LCGIS_OFF_GATE3     8'h18
`define LCGIS_OFF_POL       8'h1C
`define LCGIS_OFF_STATUS    8'h20

`define LCGIS_SEL_MSB       4
`define LCGIS_SEL_LSB       0
`define LCGIS_SEL_W         5
`define LCGIS_GLS_W         8
`define LCGIS_NUM_DATA      4
`define LCGIS_NUM_GATES     3

`define LCGIS_RST_SEL       5'h00
`define LCGIS_RST_GLS       8'h00
`define LCGIS_RST_POL       3'h0
`define LCGIS_RST_GATE      3'h0
`define LCGIS_RST_WORD      32'h0000_0000

`endif

// ---- common/lcgis_pkg.sv ----
// Types of the logic cell gate input select stage.
// Assumes lcgis_defs.svh is on the include path.
`include "lcgis_defs.svh"

package lcgis_pkg;

    typedef struct packed {
        logic [`LCGIS_ADDR_W-1:0] paddr;
        logic                     psel;
        logic                     penable;
        logic                     pwrite;
        logic [`LCGIS_DATA_W-1:0] pwdata;
    } lcgis_apb_req_t;

    typedef struct packed {
        logic [`LCGIS_DATA_W-1:0] prdata;
        logic                     pready;
        logic                     pslverr;
    } lcgis_apb_rsp_t;

    typedef struct packed {
        logic [`LCGIS_NUM_DATA-1:0][`LCGIS_SEL_W-1:0]  srcSel;
        logic [`LCGIS_NUM_GATES-1:0][`LCGIS_GLS_W-1:0] gateEnable;
        logic [`LCGIS_NUM_GATES-1:0]                   gateInvert;
        logic [`LCGIS_NUM_GATES-1:0]                   gateOut;
        lcgis_apb_rsp_t                                rsp;
    } lcgis_state_t;

endpackage

// ---- rtl/lcgis_gate.sv ----
// One input gate: ORs the enabled true and inverted data inputs, then applies
// the gate's polarity. Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module lcgis_gate #(
    parameter int NUM_INPUTS = 4
) (
    // Selected data inputs, true versions.
    input  wire logic [NUM_INPUTS-1:0]   dataTrue,
    // Enables: odd bit admits the true version, even bit the inverted one.
    input  wire logic [2*NUM_INPUTS-1:0] enable,
    input  wire logic                    invert,
    // Gate result after polarity.
    output logic                         gateOut
);

    logic [2*NUM_INPUTS-1:0] versions;

    always_comb
    begin
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            versions[2*i+1] = dataTrue[i];                   // R10
            versions[2*i]   = ~dataTrue[i];                  // R10
        end
        // With no enable set the OR is zero before polarity.
        gateOut = (|(versions & enable)) ^ invert;           // R3 R6 R9 R10
    end

endmodule // lcgis_gate

`default_nettype wire

// ---- tb/lcgis_top_properties.sv ----
// Checker of the APB answers of the gate input select stage.
// Assumes the zero-wait slave timing of lcgis_top.
`timescale 1ns/1ps
`default_nettype none
`include "lcgis_defs.svh"
module lcgis_top_check
    import lcgis_pkg::*;
#(
    parameter int NUM_SOURCES = 32
) (
    // Clock and reset.
    input wire logic                        clk,
    input wire logic                        rst,
    // Watched ports.
    input wire lcgis_apb_req_t              apbReq,
    input wire lcgis_apb_rsp_t              apbRsp,
    input wire logic [NUM_SOURCES-1:0]      sourceBus,
    input wire logic [`LCGIS_NUM_GATES-1:0] gateOut
);
    logic setupPhase;
    logic readAcc;
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign readAcc = apbRsp.pready && !apbReq.pwrite;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ready_after_setup_a: assert property (setupPhase |=> apbRsp.pready)
        else $error("no ready after setup");
    ready_needs_setup_a: assert property (!setupPhase |=> !apbRsp.pready)
        else $error("ready without setup");
    sel4_upper_zero_a: assert property (readAcc && apbReq.paddr == `LCGIS_OFF_SEL4
        |-> apbRsp.prdata[31:5] == 27'h0) else $error("sel4 upper bits set");
    sel_upper_zero_a: assert property (readAcc && apbReq.paddr < `LCGIS_OFF_SEL4
        |-> apbRsp.prdata[31:5] == 27'h0) else $error("selector upper bits set");
    gate_upper_zero_a: assert property (readAcc && apbReq.paddr[7:4] == 4'h1
        |-> apbRsp.prdata[31:8] == 24'h0) else $error("enable upper bits set");
    idle_data_zero_a: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
        else $error("read data outside access");
    unmapped_error_a: assert property (apbRsp.pready && apbReq.paddr > `LCGIS_OFF_STATUS
        |-> apbRsp.pslverr) else $error("no error on unmapped");
    mapped_no_error_a: assert property (apbRsp.pready && apbReq.paddr[1:0] == 2'h0
        && apbReq.paddr <= `LCGIS_OFF_STATUS |-> !apbRsp.pslverr) else $error("error on mapped");
    status_mirror_a: assert property (readAcc && apbReq.paddr == `LCGIS_OFF_STATUS
        |-> apbRsp.prdata[2:0] == $past(gateOut)) else $error("status differs from gates");
    gate_change_cause_a: assert property ($changed(gateOut)
        |-> $past(sourceBus) != $past(sourceBus, 2) || $past(apbRsp.pready && apbReq.pwrite, 2))
        else $error("gate changed without cause");
endmodule // lcgis_top_check
bind lcgis_top lcgis_top_check #(.NUM_SOURCES(NUM_SOURCES)) check (.clk(clk), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .sourceBus(sourceBus), .gateOut(gateOut));
`default_nettype wire

// ---- tb/test_lcgis_top.sv ----
// Self-checking bench of the gate input select stage.
// Assumes gate outputs that follow a change within two rising clock edges.
`timescale 1ns/1ps
`default_nettype none
`include "lcgis_defs.svh"
module test_lcgis_top
    import lcgis_pkg::*;
;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    lcgis_apb_req_t req = '0;
    lcgis_apb_rsp_t apbRsp;
    logic [31:0]    sourceBus = 32'h0;
    logic [2:0]     gateOut;
    logic [31:0]    rd;
    logic           er;
    int             err_total = 0;
    int             comparisons = 0;
    int             cycles = 0;
    always #25 clk = ~clk;
    lcgis_top #(.NUM_SOURCES(32)) DUT (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(apbRsp),
        .sourceBus(sourceBus), .gateOut(gateOut));
    task automatic finish_test();
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Ready, read data and error are taken at the rising edge that sees ready high.
    // Read in that edge's own time step they still show what the previous edge launched.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (apbRsp.pready !== 1'b1)
            check("pready", 32'h1, 32'h0);
    endtask
    // A change driven at one rising edge reaches the gate pins at the next one.
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask
    task automatic test_select4();
        apb(1'b0, `LCGIS_OFF_SEL4, 32'h0);
        check("sel4 reset", 32'h0, rd);
        apb(1'b1, `LCGIS_OFF_SEL4, 32'hFFFF_FFFF);
        apb(1'b0, `LCGIS_OFF_SEL4, 32'h0);
        check("sel4 ones", 32'h1F, rd);
        apb(1'b1, `LCGIS_OFF_SEL4, 32'h15);
        apb(1'b0, `LCGIS_OFF_SEL4, 32'h0);
        check("sel4 field", 32'h15, rd);
    endtask
    task automatic test_gates();
        logic [31:0] s;
        logic [2:0]  e;
        for (int i = 0; i < 4; i++)
            apb(1'b1, `LCGIS_OFF_SEL1 + 8'(4 * i), 32'(i));
        for (int g = 0; g < 3; g++)
        begin
            for (int b = 0; b < 16; b++)
            begin
                s = b[0] ? 32'hA : 32'h5;
                sourceBus <= s;
                apb(1'b1, `LCGIS_OFF_GATE1 + 8'(4 * g), 32'h1 << (b / 2));
                settle();
                e = 3'h0;
                e[g] = b[1] ? s[b / 4] : !s[b / 4];
                check("gate bit", 32'(e), 32'(gateOut));
            end
            apb(1'b1, `LCGIS_OFF_GATE1 + 8'(4 * g), 32'h0);
        end
    endtask
    task automatic test_or_pol();
        sourceBus <= 32'h9;
        apb(1'b1, `LCGIS_OFF_GATE2, 32'hA0);
        settle();
        check("gate or", 32'h2, 32'(gateOut));
        apb(1'b1, `LCGIS_OFF_POL, 32'h7);
        settle();
        check("polarity", 32'h5, 32'(gateOut));
        apb(1'b1, `LCGIS_OFF_POL, 32'h0);
        apb(1'b1, `LCGIS_OFF_GATE2, 32'h0);
    endtask
    task automatic test_source_index();
        apb(1'b1, `LCGIS_OFF_SEL1, 32'h1F);
        apb(1'b1, `LCGIS_OFF_GATE1, 32'h2);
        sourceBus <= 32'h8000_0000;
        settle();
        check("source high", 32'h1, 32'(gateOut));
        sourceBus <= 32'h7FFF_FFFF;
        settle();
        check("source low", 32'h0, 32'(gateOut));
        apb(1'b0, `LCGIS_OFF_GATE1, 32'h0);
        check("gate1 read", 32'h2, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", 32'h1, 32'(er));
    endtask
    task automatic test_readback();
        apb(1'b1, `LCGIS_OFF_POL, 32'hFFFF_FFFD);
        apb(1'b0, `LCGIS_OFF_POL, 32'h0);
        check("pol read", 32'h5, rd);
        apb(1'b0, `LCGIS_OFF_STATUS, 32'h0);
        check("status read", 32'h5, rd);
        apb(1'b1, `LCGIS_OFF_STATUS, 32'hFFFF_FFFF);
        check("status write err", 32'h0, 32'(er));
        apb(1'b1, `LCGIS_OFF_GATE3, 32'hFFFF_FF81);
        apb(1'b0, `LCGIS_OFF_GATE3, 32'h0);
        check("gate3 read", 32'h81, rd);
        check("mapped err", 32'h0, 32'(er));
        settle();
        check("gate3 out", 32'h1, 32'(gateOut));
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, `LCGIS_OFF_SEL1 + 8'(4 * i), 32'h0);
            check("sel read", (i == 0) ? 32'h1F : 32'(i), rd);
        end
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        test_select4();
        test_gates();
        test_or_pol();
        test_source_index();
        test_readback();
        finish_test();
    end
endmodule // test_lcgis_top
`default_nettype wire
